/* File: rtl/can_accept_defs.svh */
// Register offsets, field positions and reset values of the acceptance filter
`ifndef CAN_ACCEPT_DEFS_SVH
`define CAN_ACCEPT_DEFS_SVH
`define REG_FLT_STD_BASE 8'h00
`define REG_FLT_EXT_BASE 8'h10
`define REG_MSKSEL_LOW 8'h20
`define REG_MSKSEL_HIGH 8'h21
`define REG_FLT_ENABLE 8'h22
`define REG_BUFPTR_BASE 8'h24
`define REG_MSK_STD_BASE 8'h28
`define REG_MSK_EXT_BASE 8'h2C
`define REG_MATCH_STATUS 8'h30
`define STD_WRITE_MASK 16'hFFEB
`define MSKSEL_RESET 16'h0000
`define FLT_ENABLE_RESET 16'hFFFF
`define BUFPTR_RESET 16'h0000
`define TYPE_BIT 3
`define MASK_SRC_RESERVED 2'h3
`define BUF_PTR_FIFO 4'hF
`endif

/* File: rtl/can_accept_pkg.sv */
// Types shared by the acceptance filter design
package can_accept_pkg;
  typedef struct packed {
    logic [10:0] std_identifier_bits;
    logic [17:0] ext_identifier_bits;
    logic is_extended;
  } rx_ident_t;
  typedef struct packed {
    logic hit;
    logic [3:0] filter_index;
    logic [3:0] filter_buffer_pointer;
  } match_result_t;
  typedef enum logic [1:0] {
    st_idle = 2'b01,
    st_done = 2'b10
  } match_state_t;
endpackage

/* File: rtl/can_acceptance_filter_match.sv */
// Acceptance filter bank, masks and match logic of the CAN receive path
//
// What this block does
// - Sixteen filters, each with 11-bit standard and 18-bit extended pattern.
// - Mask-included standard bits must equal filter pattern bits.
// - Mask-included 18 extended bits must match; upper two in std word.
// - With type matching, extended-select one accepts only extended frames.
// - Without type matching, filter extended-select is ignored.
// - Three shared masks with standard, extended and type-matching bits.
// - Mask standard bit one compares that bit, zero is don't care.
// - Mask extended bit one compares that bit, zero is don't care.
// - Type-match set: accept only the type given by the filter select.
// - Type-match clear: standard bits for std, all bits for extended.
// - Two-bit mask source per filter: 00, 01, 10 pick masks 0-2.
// - Mask sources packed in two words, eight filters each, reset zero.
// - Bits 4 and 2 of standard words read zero; ids unknown at reset.
// - Only enabled filters take part; enables reset to one.
// - Hit reports the filter's 4-bit buffer pointer; 1111 means FIFO.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "can_accept_defs.svh"
module can_acceptance_filter_match #(
  parameter int NUM_FILTERS = 16,
  parameter int NUM_MASKS = 3
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  input wire logic id_valid,
  input wire can_accept_pkg::rx_ident_t id_in,
  output logic match_valid,
  output can_accept_pkg::match_result_t match_out
);
  import can_accept_pkg::*;

  // Identifier words carry no reset: software must write them before use
  logic [15:0] flt_std [NUM_FILTERS];
  logic [15:0] flt_ext [NUM_FILTERS];
  logic [15:0] msk_std [NUM_MASKS];
  logic [15:0] msk_ext [NUM_MASKS];
  logic [15:0] msksel_low;
  logic [15:0] msksel_high;
  logic [15:0] flt_enable;
  logic [15:0] bufptr [4];
  logic [15:0] next_msksel_low;
  logic [15:0] next_msksel_high;
  logic [15:0] next_flt_enable;
  logic [15:0] next_bufptr [4];
  logic [15:0] next_rdata;
  logic [15:0] rdata_mux;
  match_state_t state;
  match_state_t next_state;
  match_result_t result;
  match_result_t next_result;
  match_result_t last_result;
  match_result_t next_last_result;
  logic next_valid;
  logic [NUM_FILTERS-1:0] filter_hit;
  logic [31:0] src_all;

  // Next values of the identifier bank
  logic [15:0] next_flt_std [NUM_FILTERS];
  logic [15:0] next_flt_ext [NUM_FILTERS];
  logic [15:0] next_msk_std [NUM_MASKS];
  logic [15:0] next_msk_ext [NUM_MASKS];
  // Address decode flags
  logic at_flt_std;
  logic at_flt_ext;
  logic at_msk_std;
  logic at_msk_ext;
  logic at_bufptr;
  logic [3:0] word_idx;
  logic [1:0] low_idx;

  assign src_all = {msksel_high, msksel_low};

  // Address decode, each compare made at the width of the field it tests
  always_comb
  begin
    word_idx = reg_addr[3:0];
    low_idx = reg_addr[1:0];
    at_flt_std = reg_addr[7:4] == 4'(`REG_FLT_STD_BASE >> 4);
    at_flt_ext = reg_addr[7:4] == 4'(`REG_FLT_EXT_BASE >> 4);
    at_bufptr = reg_addr[7:2] == 6'(`REG_BUFPTR_BASE >> 2);
    // The fourth word of each mask block is a hole: only three masks exist
    at_msk_std = reg_addr[7:2] == 6'(`REG_MSK_STD_BASE >> 2) &&
                 low_idx != 2'h3;
    at_msk_ext = reg_addr[7:2] == 6'(`REG_MSK_EXT_BASE >> 2) &&
                 low_idx != 2'h3;
  end

  // Per-filter comparison
  always_comb
  begin
    logic [1:0] src;
    logic [15:0] ms;
    logic [15:0] me;
    logic [10:0] pat_std;
    logic [17:0] pat_ext;
    logic [10:0] inc_std;
    logic [17:0] inc_ext;
    logic type_match;
    logic ext_sel;
    logic std_ok;
    logic ext_ok;
    logic type_ok;
    src = 2'h0;
    ms = 16'h0000;
    me = 16'h0000;
    pat_std = 11'h000;
    pat_ext = 18'h00000;
    inc_std = 11'h000;
    inc_ext = 18'h00000;
    type_match = 1'b0;
    ext_sel = 1'b0;
    std_ok = 1'b0;
    ext_ok = 1'b0;
    type_ok = 1'b0;
    filter_hit = '0;
    for (int f = 0; f < NUM_FILTERS; f++)
    begin
      src = src_all[2*f +: 2];
      // Reserved code falls back to mask zero rather than an X mask
      case (src)
        2'h1: begin ms = msk_std[1]; me = msk_ext[1]; end
        2'h2: begin ms = msk_std[2]; me = msk_ext[2]; end
        default: begin ms = msk_std[0]; me = msk_ext[0]; end
      endcase
      pat_std = flt_std[f][15:5];
      pat_ext = {flt_std[f][1:0], flt_ext[f]};
      inc_std = ms[15:5];
      inc_ext = {ms[1:0], me};
      type_match = ms[`TYPE_BIT];
      ext_sel = flt_std[f][`TYPE_BIT];
      std_ok = ((pat_std ^ id_in.std_identifier_bits) & inc_std) == '0;
      ext_ok = ((pat_ext ^ id_in.ext_identifier_bits) & inc_ext) == '0;
      // Extended bits only count for extended frames
      if (!id_in.is_extended)
        ext_ok = 1'b1;
      // Without type matching the select bit plays no part
      type_ok = type_match ? (ext_sel == id_in.is_extended) : 1'b1;
      filter_hit[f] = flt_enable[f] && std_ok && ext_ok && type_ok;
    end
  end

  always_comb
  begin
    next_state = state;
    next_result = result;
    next_valid = 1'b0;
    next_last_result = last_result;
    case (state)
      st_idle:
      begin
        if (id_valid)
        begin
          next_result = '0;
          // Walk downwards so the lowest-numbered hit is written last and wins
          for (int f = NUM_FILTERS - 1; f >= 0; f--)
          begin
            if (filter_hit[f])
            begin
              next_result.hit = 1'b1;
              next_result.filter_index = 4'(f);
              next_result.filter_buffer_pointer = bufptr[f/4][4*(f%4) +: 4];
            end
          end
          next_valid = 1'b1;
          next_last_result = next_result;
          next_state = st_done;
        end
      end
      st_done:
      begin
        // A strobe in this cycle is dropped, not queued: there is no buffer
        next_state = st_idle;
      end
      default:
      begin
        next_state = st_idle;
      end
    endcase
  end

  // Register bus write and read decode
  always_comb
  begin
    next_msksel_low = msksel_low;
    next_msksel_high = msksel_high;
    next_flt_enable = flt_enable;
    for (int i = 0; i < 4; i++)
      next_bufptr[i] = bufptr[i];
    if (reg_write)
    begin
      case (reg_addr)
        `REG_MSKSEL_LOW: next_msksel_low = reg_wdata;
        `REG_MSKSEL_HIGH: next_msksel_high = reg_wdata;
        `REG_FLT_ENABLE: next_flt_enable = reg_wdata;
        default:
        begin
          if (at_bufptr)
            next_bufptr[low_idx] = reg_wdata;
        end
      endcase
    end
    rdata_mux = 16'h0000;
    if (at_flt_std)
      rdata_mux = flt_std[word_idx] & `STD_WRITE_MASK;
    else if (at_flt_ext)
      rdata_mux = flt_ext[word_idx];
    else if (reg_addr == `REG_MSKSEL_LOW)
      rdata_mux = msksel_low;
    else if (reg_addr == `REG_MSKSEL_HIGH)
      rdata_mux = msksel_high;
    else if (reg_addr == `REG_FLT_ENABLE)
      rdata_mux = flt_enable;
    else if (at_bufptr)
      rdata_mux = bufptr[low_idx];
    else if (at_msk_std)
      rdata_mux = msk_std[low_idx] & `STD_WRITE_MASK;
    else if (at_msk_ext)
      rdata_mux = msk_ext[low_idx];
    else if (reg_addr == `REG_MATCH_STATUS)
      rdata_mux = {7'h00, last_result.hit, last_result.filter_index,
                   last_result.filter_buffer_pointer};
    // Idle cycles read zero so stale data never passes for a fresh read
    next_rdata = reg_read ? rdata_mux : 16'h0000;
  end

  // Identifier words: unimplemented bits are dropped as they are stored
  always_comb
  begin
    for (int i = 0; i < NUM_FILTERS; i++)
    begin
      next_flt_std[i] = flt_std[i];
      next_flt_ext[i] = flt_ext[i];
    end
    for (int i = 0; i < NUM_MASKS; i++)
    begin
      next_msk_std[i] = msk_std[i];
      next_msk_ext[i] = msk_ext[i];
    end
    if (reg_write && at_flt_std)
      next_flt_std[word_idx] = reg_wdata & `STD_WRITE_MASK;
    if (reg_write && at_flt_ext)
      next_flt_ext[word_idx] = reg_wdata;
    if (reg_write && at_msk_std)
      next_msk_std[low_idx] = reg_wdata & `STD_WRITE_MASK;
    if (reg_write && at_msk_ext)
      next_msk_ext[low_idx] = reg_wdata;
  end

  // Left out of reset, so the identifier bank stays plain storage
  always_ff @(posedge clk)
  begin
    for (int i = 0; i < NUM_FILTERS; i++)
    begin
      flt_std[i] <= next_flt_std[i];
      flt_ext[i] <= next_flt_ext[i];
    end
    for (int i = 0; i < NUM_MASKS; i++)
    begin
      msk_std[i] <= next_msk_std[i];
      msk_ext[i] <= next_msk_ext[i];
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      msksel_low <= `MSKSEL_RESET;
      msksel_high <= `MSKSEL_RESET;
      flt_enable <= `FLT_ENABLE_RESET;
      for (int i = 0; i < 4; i++)
        bufptr[i] <= `BUFPTR_RESET;
      reg_rdata <= 16'h0000;
      state <= st_idle;
      result <= '0;
      last_result <= '0;
      match_valid <= 1'b0;
      match_out <= '0;
    end
    else
    begin
      msksel_low <= next_msksel_low;
      msksel_high <= next_msksel_high;
      flt_enable <= next_flt_enable;
      for (int i = 0; i < 4; i++)
        bufptr[i] <= next_bufptr[i];
      reg_rdata <= next_rdata;
      state <= next_state;
      result <= next_result;
      last_result <= next_last_result;
      match_valid <= next_valid;
      match_out <= next_result;
    end
  end
endmodule // can_acceptance_filter_match

/* File: tb/can_accept_chk.sv */
// Port assertions for the acceptance filter
`timescale 1ns/1ps
module can_accept_chk #(
  parameter int NUM_FILTERS = 16,
  parameter int NUM_MASKS = 3
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  input wire logic id_valid,
  input wire logic match_valid,
  input wire can_accept_pkg::match_result_t match_out
);
  import can_accept_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  chk_answer_next:
    assert property (id_valid && !match_valid |=> match_valid)
    else $error("no answer");
  chk_answer_cause:
    assert property (match_valid |-> $past(id_valid))
    else $error("stray answer");
  chk_answer_pulse:
    assert property (match_valid |=> !match_valid)
    else $error("long answer");
  chk_result_hold:
    assert property (!match_valid |-> $stable(match_out))
    else $error("result moved");
  chk_miss_zero:
    assert property (match_valid && !match_out.hit |-> match_out[7:0] == 8'h00)
    else $error("miss not clear");
  chk_rdata_idle:
    assert property (!reg_read |=> reg_rdata == 16'h0000)
    else $error("stale read");
  chk_spare_zero:
    assert property (reg_read && (reg_addr < 8'h10 || reg_addr inside
      {[8'h28:8'h2A]}) |=> reg_rdata[4] == 1'b0 && reg_rdata[2] == 1'b0)
    else $error("spare bit set");
  chk_unmapped_zero:
    assert property (reg_read && reg_addr > 8'h30 |=> reg_rdata == 16'h0000)
    else $error("unmapped read");
endmodule // can_accept_chk
bind can_acceptance_filter_match can_accept_chk #(
  .NUM_FILTERS(NUM_FILTERS), .NUM_MASKS(NUM_MASKS)) i_can_accept_chk (
  .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .id_valid(id_valid), .match_valid(match_valid),
  .match_out(match_out));

/* File: tb/can_rx_source.sv */
// Receive-path model that hands identifiers to the filter
`timescale 1ns/1ps
module can_rx_source (
  input wire logic clk,
  output logic id_valid,
  output can_accept_pkg::rx_ident_t id_in
);
  import can_accept_pkg::*;
  initial
  begin
    id_valid = 1'b0;
    id_in = '0;
  end
  // Idle lines show the inverse so a late sample cannot match by luck
  task automatic send(input rx_ident_t id, input int gap, input bit again);
    repeat (gap) @(posedge clk);
    id_valid <= 1'b1;
    id_in <= id;
    @(posedge clk);
    // A second strobe right behind the first lands in the refused cycle
    id_valid <= again;
    id_in <= ~id;
    if (again)
    begin
      @(posedge clk);
      id_valid <= 1'b0;
    end
  endtask
endmodule // can_rx_source

/* File: tb/can_acceptance_filter_match_tb.sv */
// Bench for the acceptance filter against a reference model
`timescale 1ns/1ps
module can_acceptance_filter_match_tb;
  import can_accept_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic id_valid, match_valid;
  rx_ident_t id_in, id;
  match_result_t match_out;
  int err_total = 0, num_checks = 0, cycles = 0;
  int fs[16], fe[16], ms[3], me[3], bp[16], sel, en, v;
  bit again;
  always #2.5 clk = ~clk;
  can_acceptance_filter_match i_can_acceptance_filter_match (.clk(clk),
    .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .id_valid(id_valid), .id_in(id_in), .match_valid(match_valid),
    .match_out(match_out));
  can_rx_source i_can_rx_source (.clk(clk), .id_valid(id_valid),
    .id_in(id_in));
  task automatic stop_test();
    if (err_total == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      err_total++;
      stop_test();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("ERROR %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    {reg_addr, reg_read} <= {a, 1'b1};
    @(posedge clk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  function automatic logic [8:0] model(input rx_ident_t id);
    logic [8:0] r;
    int m, d;
    r = 9'h000;
    for (int f = 15; f >= 0; f--)
    begin
      m = sel[2*f +: 2];
      d = (ms[m] >> 5) & ((fs[f] >> 5) ^ id.std_identifier_bits);
      if (id.is_extended)
        d |= {ms[m][1:0], me[m][15:0]} & ({fs[f][1:0], fe[f][15:0]}
          ^ id.ext_identifier_bits);
      if (ms[m][3] && fs[f][3] != id.is_extended)
        d = 1;
      if (en[f] && d == 0)
        r = {1'b1, 4'(f), 4'(bp[f])};
    end
    return r;
  endfunction
  initial
  begin
    void'($urandom(13728));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(8'h20, 16'h0000);
    rd(8'h21, 16'h0000);
    rd(8'h22, 16'hFFFF);
    rd(8'h24, 16'h0000);
    repeat (4)
    begin
      for (int i = 0; i < 19; i++)
      begin
        v = $urandom;
        wr(8'(i < 16 ? i : 8'h18 + i), v[15:0]);
        wr(8'(i < 16 ? 8'h10 + i : 8'h1C + i), v[31:16]);
        rd(8'(i < 16 ? i : 8'h18 + i), v[15:0] & 16'hFFEB);
        rd(8'(i < 16 ? 8'h10 + i : 8'h1C + i), v[31:16]);
        if (i < 16) fs[i] = v[15:0] & 16'hFFEB;
        else ms[i-16] = v[15:0] & 16'hFFEB;
        if (i < 16) fe[i] = v[31:16];
        else me[i-16] = v[31:16];
        bp[i % 16] = (i < 16) ? $urandom_range(15) : bp[i % 16];
      end
      sel = $urandom;
      sel = sel & ~((sel & (sel >> 1) & 32'h55555555) << 1);
      en = $urandom | $urandom;
      wr(8'h20, sel[15:0]);
      wr(8'h21, sel[31:16]);
      wr(8'h22, en[15:0]);
      for (int k = 0; k < 4; k++)
        wr(8'(8'h24 + k), 16'({bp[4*k+3][3:0], bp[4*k+2][3:0],
          bp[4*k+1][3:0], bp[4*k][3:0]}));
      rd(8'h21, sel[31:16]);
      rd(8'h23, 16'h0000);
      for (int k = 0; k < 40; k++)
      begin
        v = $urandom_range(15);
        id = {11'(fs[v] >> 5), fs[v][1:0], fe[v][15:0], 1'($urandom)};
        id = id ^ (30'h1 << $urandom_range(40));
        // Every eighth request is chased by one that must be refused
        again = (k % 8 == 4);
        i_can_rx_source.send(id, 1 + $urandom_range(2), again);
        #1 check(16'(match_valid), 16'(!again));
        check(16'(match_out), 16'(model(id)));
        if (k % 8 == 0) rd(8'h30, 16'(model(id)));
      end
    end
    stop_test();
  end
endmodule // can_acceptance_filter_match_tb
